// ===== bsf_fir.v
// bit-serial fir engine with axi4-lite control registers
`include "bsf_regs.vh"

module bsf_fir (
  input wire clk_i,
  input wire reset_n_i,
  input wire [2*`BSF_W-1:0] din_i,
  input wire irdy_i,
  input wire real_in_i,
  input wire [`BSF_W-1:0] coeff_i,
  input wire loadc_i,
  output wire [2*`BSF_OW-1:0] dout_o,
  output wire ordy_o,
  output wire real_out_o,
  input wire [3:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output wire [1:0] s_axi_bresp_o,
  output wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [3:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0] s_axi_rresp_o,
  output wire s_axi_rvalid_o,
  input wire s_axi_rready_i
);

  ////////////////////////////////////////////////////////////////////////////
  // register slave

  reg [15:0] ctrl_reg;
  reg [3:0] awaddr_reg;
  reg aw_full_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg w_full_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;
  reg [15:0] out_cnt_reg;
  reg [31:0] rd_mux;

  wire fixed_on = ctrl_reg[`BSF_F_FIXED];
  wire rnd_on = ctrl_reg[`BSF_F_RND];
  wire uns_on = ctrl_reg[`BSF_F_UNS];
  wire [1:0] sym_mode = ctrl_reg[`BSF_F_SYM_LO+1:`BSF_F_SYM_LO];
  wire cpxp_on = ctrl_reg[`BSF_F_CPXP];
  wire cpxs_on = ctrl_reg[`BSF_F_CPXS];
  wire [3:0] dec_ratio = ctrl_reg[`BSF_F_DEC_LO+3:`BSF_F_DEC_LO];
  wire [3:0] int_ratio = ctrl_reg[`BSF_F_INT_LO+3:`BSF_F_INT_LO];
  wire int_on = (int_ratio > 4'h1);
  wire sym_on = (sym_mode == 2'h1) | (sym_mode == 2'h2);

  assign s_axi_awready_o = ~aw_full_reg & ~bvalid_reg;
  assign s_axi_wready_o = ~w_full_reg & ~bvalid_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = ~rvalid_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;

  wire wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;

  // address and data taken in either order, answered once both are held
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctrl_reg <= `BSF_CTRL_RST;
      awaddr_reg <= 4'h0;
      aw_full_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      w_full_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `BSF_RESP_OK;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        awaddr_reg <= s_axi_awaddr_i;
        aw_full_reg <= 1'b1;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
        w_full_reg <= 1'b1;
      end
      if (wr_go) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        if (awaddr_reg == `BSF_CTRL_OFS) begin
          bresp_reg <= `BSF_RESP_OK;
          if (wstrb_reg[0]) ctrl_reg[7:0] <= wdata_reg[7:0];
          if (wstrb_reg[1]) ctrl_reg[15:8] <= wdata_reg[15:8];
        end else if (awaddr_reg == `BSF_STAT_OFS || awaddr_reg == `BSF_OCNT_OFS) begin
          bresp_reg <= `BSF_RESP_OK; // read-only, write dropped
        end else begin
          bresp_reg <= `BSF_RESP_ERR;
        end
      end else if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing: period counter and batch base

  reg [`BSF_CNT_W-1:0] cnt_reg;
  reg [`BSF_TAP_AW:0] base_reg;
  reg [`BSF_TAP_AW-1:0] ptr_reg;
  reg pend_reg;
  reg pend_real_reg;
  reg cur_real_reg;
  reg [3:0] dec_cnt_reg;
  reg ordy_reg;
  reg real_out_reg;

  wire pp_end = (cnt_reg == `BSF_CNT_LAST);
  wire out_end = pp_end && (base_reg == `BSF_LAST_BASE);
  wire bit_phase = (cnt_reg <= `BSF_BIT_LAST);
  wire [`BSF_BIT_AW-1:0] bit_idx = cnt_reg[`BSF_BIT_AW-1:0];
  wire coef_neg = ~uns_on & (cnt_reg == `BSF_BIT_LAST);
  wire emit = (dec_cnt_reg == 4'h0);
  wire [3:0] dec_last = (dec_ratio == 4'h0) ? 4'h0 : dec_ratio - 4'h1;

  // read data mux
  always @* begin
    rd_mux = 32'h0000_0000;
    if (s_axi_araddr_i == `BSF_CTRL_OFS) begin
      rd_mux = {16'h0000, ctrl_reg};
    end else if (s_axi_araddr_i == `BSF_STAT_OFS) begin
      rd_mux = {19'h0_0000, cnt_reg, base_reg, ptr_reg, pend_reg};
    end else if (s_axi_araddr_i == `BSF_OCNT_OFS) begin
      rd_mux = {16'h0000, out_cnt_reg};
    end
  end

  // read channel, one cycle to answer
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `BSF_RESP_OK;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= (s_axi_araddr_i == `BSF_CTRL_OFS || s_axi_araddr_i == `BSF_STAT_OFS ||
                    s_axi_araddr_i == `BSF_OCNT_OFS) ? `BSF_RESP_OK : `BSF_RESP_ERR;
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end

  // period counter, batch stepping, sample and decimation bookkeeping
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_reg <= {`BSF_CNT_W{1'b0}};
      base_reg <= {(`BSF_TAP_AW+1){1'b0}};
      pend_reg <= 1'b0;
      pend_real_reg <= 1'b0;
      cur_real_reg <= 1'b0;
      dec_cnt_reg <= 4'h0;
      ordy_reg <= 1'b0;
      real_out_reg <= 1'b0;
      out_cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= pp_end ? {`BSF_CNT_W{1'b0}} : cnt_reg + 5'h01;
      if (out_end) begin
        base_reg <= {(`BSF_TAP_AW+1){1'b0}};
      end else if (pp_end) begin
        base_reg <= base_reg + `BSF_BASE_STEP;
      end
      // a new sample wins over the consume at the same edge
      if (irdy_i) begin
        pend_reg <= 1'b1;
        pend_real_reg <= real_in_i;
      end else if (out_end) begin
        pend_reg <= 1'b0;
      end
      if (out_end && pend_reg) begin
        cur_real_reg <= pend_real_reg;
      end
      ordy_reg <= out_end & emit;
      real_out_reg <= out_end & emit & cpxs_on & cur_real_reg;
      if (out_end) begin
        dec_cnt_reg <= (dec_cnt_reg >= dec_last) ? 4'h0 : dec_cnt_reg + 4'h1;
        if (emit) out_cnt_reg <= out_cnt_reg + 16'h0001;
      end
    end
  end

  assign ordy_o = ordy_reg;
  assign real_out_o = real_out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // coefficient registers

  reg [`BSF_W-1:0] coef_reg [0:`BSF_TAPS-1];
  integer ci;

  // built-in coefficient set for fixed mode
  function [`BSF_W-1:0] rom_coef;
    input [`BSF_TAP_AW-1:0] i;
    begin
      case (i)
        3'h0: rom_coef = 8'h01;
        3'h1: rom_coef = 8'h02;
        3'h2: rom_coef = 8'h03;
        3'h3: rom_coef = 8'h04;
        3'h4: rom_coef = 8'h04;
        3'h5: rom_coef = 8'h03;
        3'h6: rom_coef = 8'h02;
        default: rom_coef = 8'h01;
      endcase
    end
  endfunction

  // one word per edge while strobe high, newest tap first
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      ptr_reg <= {`BSF_TAP_AW{1'b0}};
      for (ci = 0; ci < `BSF_TAPS; ci = ci + 1) coef_reg[ci] <= 8'h00;
    end else if (loadc_i && !fixed_on) begin
      coef_reg[ptr_reg] <= coeff_i;
      ptr_reg <= ptr_reg + 3'h1;
    end else begin
      ptr_reg <= {`BSF_TAP_AW{1'b0}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // datapath lanes: lane 0 real, lane 1 imaginary

  genvar gl;
  genvar gm;
  genvar gt;
  generate
    for (gl = 0; gl < 2; gl = gl + 1) begin : g_lane
      reg [`BSF_W-1:0] tap_reg [0:`BSF_TAPS-1];
      reg [`BSF_W-1:0] hold_reg;
      reg [`BSF_OFW-1:0] acc_reg;
      reg [`BSF_OW-1:0] dout_reg;
      wire signed [`BSF_TREE_W-1:0] node [0:2*`BSF_MULS-2];
      integer ti;

      // complex-serial routes real samples to lane 0, imaginary to lane 1
      wire lane_take = cpxs_on ? ((gl == 0) ? pend_real_reg : ~pend_real_reg) : 1'b1;
      wire shift_go = out_end & ((pend_reg & lane_take) | int_on);

      // multiplier bank, one serial multiplier per slot
      for (gm = 0; gm < `BSF_MULS; gm = gm + 1) begin : g_mul
        localparam [`BSF_TAP_AW:0] SLOT = gm;
        wire [`BSF_TAP_AW:0] idx_full = base_reg + SLOT;
        wire [`BSF_TAP_AW-1:0] idx = idx_full[`BSF_TAP_AW-1:0];
        wire [`BSF_TAP_AW-1:0] pidx = `BSF_TAP_LAST - idx;
        wire [`BSF_W-1:0] tv = tap_reg[idx];
        wire [`BSF_W-1:0] pv = tap_reg[pidx];
        wire signed [`BSF_EXT_W-1:0] a = uns_on ? {2'b00, tv} : {{2{tv[`BSF_W-1]}}, tv};
        wire signed [`BSF_EXT_W-1:0] b = uns_on ? {2'b00, pv} : {{2{pv[`BSF_W-1]}}, pv};
        wire in_use = (idx_full < `BSF_TAPS) & (~sym_on | (idx_full < `BSF_TAP_HALF));
        wire signed [`BSF_EXT_W-1:0] op = (sym_mode == 2'h1) ? a + b :
                                          (sym_mode == 2'h2) ? a - b : a;
        wire [`BSF_W-1:0] cv = fixed_on ? rom_coef(idx) : coef_reg[idx];
        wire cbit = cv[bit_idx];
        wire signed [`BSF_EXT_W-1:0] pp = (in_use & cbit) ? (coef_neg ? -op : op) :
                                          {`BSF_EXT_W{1'b0}};
        assign node[`BSF_MULS-1+gm] = {{(`BSF_TREE_W-`BSF_EXT_W){pp[`BSF_EXT_W-1]}}, pp};
      end

      // binary adder tree, all levels concurrent
      for (gt = 0; gt < `BSF_MULS - 1; gt = gt + 1) begin : g_add
        assign node[gt] = node[2*gt+1] + node[2*gt+2];
      end

      wire [`BSF_OFW-1:0] term_ext = {{(`BSF_OFW-`BSF_TREE_W){node[0][`BSF_TREE_W-1]}}, node[0]};
      wire [`BSF_OFW-1:0] term = term_ext << bit_idx;
      wire [`BSF_OFW-1:0] rsum = acc_reg + (rnd_on ? `BSF_RND_HALF : {`BSF_OFW{1'b0}});

      // tap shift chain, cleared by reset
      always @(posedge clk_i) begin
        if (!reset_n_i) begin
          hold_reg <= 8'h00;
          for (ti = 0; ti < `BSF_TAPS; ti = ti + 1) tap_reg[ti] <= 8'h00;
        end else begin
          if (irdy_i) begin
            hold_reg <= (gl == 1 && cpxp_on) ? din_i[2*`BSF_W-1:`BSF_W] : din_i[`BSF_W-1:0];
          end
          if (shift_go) begin
            tap_reg[0] <= (pend_reg & lane_take) ? hold_reg : 8'h00;
            for (ti = 1; ti < `BSF_TAPS; ti = ti + 1) tap_reg[ti] <= tap_reg[ti-1];
          end
        end
      end

      // accumulator across batches and scaled output register
      always @(posedge clk_i) begin
        if (!reset_n_i) begin
          acc_reg <= {`BSF_OFW{1'b0}};
          dout_reg <= 16'h0000;
        end else if (out_end) begin
          acc_reg <= {`BSF_OFW{1'b0}};
          if (emit) dout_reg <= rsum[`BSF_OFW-1:`BSF_DROP];
        end else if (bit_phase) begin
          acc_reg <= acc_reg + term;
        end
      end

      // imaginary half reads zero unless a complex mode is on
      assign dout_o[gl*`BSF_OW +: `BSF_OW] = (gl == 0 || cpxp_on || cpxs_on) ? dout_reg :
                                              16'h0000;
    end
  endgenerate

endmodule

// ===== bsf_fir_props.sv
// timing checks on the stream and bus ports of the serial fir engine
`include "bsf_regs.vh"
module bsf_fir_props (
  input wire clk_i,
  input wire reset_n_i,
  input wire [2*`BSF_OW-1:0] dout_o,
  input wire ordy_o,
  input wire real_out_o,
  input wire s_axi_awready_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  // stream side
  a_reset_clear: assert property (disable iff (1'b0) !reset_n_i |=> dout_o == '0 && !ordy_o)
    else $error("result not cleared by reset");
  a_ordy_pulse: assert property (ordy_o |=> !ordy_o [*8])
    else $error("result strobe repeated too soon");
  a_real_flag: assert property (real_out_o |-> ordy_o)
    else $error("real flag without result strobe");
  a_dout_hold: assert property (!ordy_o |-> $stable(dout_o))
    else $error("result changed without strobe");
  ////////////////////////////////////////////////////////////////////////////////
  // register bus side
  a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_aw_block: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
    else $error("write address taken while response pending");
  a_resp_drop: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response not released");
  a_rd_drop: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read answer not released");
endmodule

bind bsf_fir bsf_fir_props i_props (
  .clk_i(clk_i),
  .reset_n_i(reset_n_i),
  .dout_o(dout_o),
  .ordy_o(ordy_o),
  .real_out_o(real_out_o),
  .s_axi_awready_o(s_axi_awready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i),
  .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i)
);

// ===== bsf_fir_tb_top.sv
// register and stream tests of the serial fir engine
module bsf_fir_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [15:0] smp = 16'h0000;
  logic [63:0] cf = 64'h110f_0d0b_0907_0503;
  logic ld = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [15:0] din;
  logic [7:0] coeff;
  logic [31:0] dout;
  logic [31:0] rdata;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic irdy, loadc, ordy, awready, wready, bvalid, arready, rvalid;
  int miscompares = 0;
  int n_compared = 0;
  int fx[8] = '{1, 2, 3, 4, 4, 3, 2, 1};
  logic [31:0] modes[4] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0008, 32'h0000_0010};
  // clock
  always #5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  bsf_src i_src (.clk_i(clk_i), .reset_n_i(reset_n_i), .smp_i(smp), .cf_i(cf), .ld_i(ld),
    .din_o(din), .irdy_o(irdy), .coeff_o(coeff), .loadc_o(loadc));
  bsf_fir i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .din_i(din), .irdy_i(irdy),
    .real_in_i(1'b0), .coeff_i(coeff), .loadc_i(loadc), .dout_o(dout), .ordy_o(ordy),
    .real_out_o(), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic lim(input bit hit);
    if (hit) begin
      miscompares++;
      $display("Error %0t: wait ran out", $time);
      summarize();
    end
  endtask
  // bus write, address and data offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    bit ha, hw, hb;
    k = 0;
    hb = 1'b0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // handshakes read mid-cycle, as the next rising edge will sample them
    do begin
      @(negedge clk_i);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = (bvalid === 1'b1);
      r = bresp;
      @(posedge clk_i);
      k++;
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end while (!hb && k < 50);
    bready <= 1'b0;
    lim(k >= 50);
  endtask
  // bus read
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    bit ha, hr;
    k = 0;
    hr = 1'b0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk_i);
      ha = arvalid && arready;
      hr = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge clk_i);
      k++;
      if (ha) arvalid <= 1'b0;
    end while (!hr && k < 50);
    rready <= 1'b0;
    lim(k >= 50);
  endtask
  // next result and the cycles waited for it
  task automatic getout(output logic [31:0] v, output int g);
    g = 0;
    do begin
      @(negedge clk_i);
      g++;
    end while (ordy !== 1'b1 && g < 300);
    v = dout;
    lim(g >= 300);
  endtask
  // impulse response of one mode: loaded, fixed, even and odd symmetric
  task automatic run(input int m);
    logic [31:0] res[14];
    logic [1:0] r;
    int k, f, g, c;
    wr(4'h0, modes[m], r);
    ld <= 1'b1;
    @(posedge clk_i);
    ld <= 1'b0;
    smp <= 16'h0040;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (irdy !== 1'b1 && k < 100);
    @(posedge clk_i);
    smp <= 16'h0000;
    lim(k >= 100);
    for (k = 0; k < 14; k++) getout(res[k], g);
    chk(32'(g), 32'h0000_002c);
    f = 0;
    while (f < 5 && res[f] === 32'h0000_0000) f++;
    for (k = 0; k < 8; k++) begin
      c = (m == 1) ? fx[k] : (m >= 2 && k > 3) ? 17 - 2 * k : 3 + 2 * k;
      if (m == 3 && k > 3) c = -c;
      chk(res[f + k], {16'h0000, 16'(2 * c)});
    end
    chk(res[f + 8], 32'h0000_0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] v;
    logic [1:0] r;
    int g;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(4'h0, v, r);
    chk(v, 32'h0000_0000);
    wr(4'h0, 32'h0000_325b, r);
    chk({30'h0, r}, 32'h0000_0000);
    rd(4'h0, v, r);
    chk(v, 32'h0000_325b);
    wr(4'h4, 32'h0000_ffff, r);
    chk({30'h0, r}, 32'h0000_0000);
    wr(4'hc, 32'h0000_0001, r);
    chk({30'h0, r}, 32'h0000_0002);
    rd(4'hc, v, r);
    chk({30'h0, r}, 32'h0000_0002);
    for (int m = 0; m < 4; m++) run(m);
    wr(4'h0, 32'h0000_0200, r);
    getout(v, g);
    getout(v, g);
    chk(32'(g), 32'h0000_0058);
    summarize();
  end
endmodule

// ===== bsf_regs.vh
// constants, offsets, field positions and timing counts of the serial fir engine
`ifndef BSF_REGS_VH
`define BSF_REGS_VH

// datapath geometry
`define BSF_TAPS 8
`define BSF_TAP_AW 3
`define BSF_TAP_LAST 3'h7
`define BSF_TAP_HALF 4'h4
`define BSF_W 8
`define BSF_BIT_AW 3
`define BSF_CYC 2
`define BSF_MULS 4
`define BSF_LAST_BASE 4'h4
`define BSF_BASE_STEP 4'h4
`define BSF_EXT_W 10
`define BSF_TREE_W 12
`define BSF_OFW 21
`define BSF_OW 16
`define BSF_DROP 5
`define BSF_RND_HALF 21'h00_0010

// processing period is full output width plus one cycles
`define BSF_PP_CYC 22
`define BSF_CNT_W 5
`define BSF_CNT_LAST 5'h15
`define BSF_BIT_LAST 5'h07

// register byte offsets
`define BSF_CTRL_OFS 4'h0
`define BSF_STAT_OFS 4'h4
`define BSF_OCNT_OFS 4'h8

// control fields
`define BSF_F_FIXED 0
`define BSF_F_RND 1
`define BSF_F_UNS 2
`define BSF_F_SYM_LO 3
`define BSF_F_CPXP 5
`define BSF_F_CPXS 6
`define BSF_F_DEC_LO 8
`define BSF_F_INT_LO 12
`define BSF_CTRL_RST 16'h0000

// bus answers
`define BSF_RESP_OK 2'h0
`define BSF_RESP_ERR 2'h2

`endif

// ===== bsf_src.sv
// upstream sample and coefficient source for the serial fir engine
module bsf_src (
  input wire clk_i,
  input wire reset_n_i,
  input wire [15:0] smp_i,
  input wire [63:0] cf_i,
  input wire ld_i,
  output logic [15:0] din_o = 16'h0000,
  output logic irdy_o = 1'b0,
  output logic [7:0] coeff_o = 8'h00,
  output logic loadc_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cnt_reg = 6'h00;
  logic [3:0] ld_reg = 4'h0;
  // one sample slot at the first cycle of every 44-cycle output period
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_reg <= 6'h00;
      irdy_o <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg == 6'h2b) ? 6'h00 : cnt_reg + 6'h01;
      irdy_o <= (cnt_reg == 6'h2b);
    end
    din_o <= (cnt_reg == 6'h2b) ? smp_i : ~din_o;
  end
  // coefficient burst, newest tap first, bus toggles when idle
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      ld_reg <= 4'h0;
      loadc_o <= 1'b0;
    end else if (ld_i || ld_reg != 4'h0) begin
      loadc_o <= (ld_reg != 4'h8);
      ld_reg <= (ld_reg == 4'h8) ? 4'h0 : ld_reg + 4'h1;
    end
    if (ld_reg != 4'h8 && (ld_i || ld_reg != 4'h0)) begin
      coeff_o <= cf_i[8*ld_reg[2:0] +: 8];
    end else begin
      coeff_o <= ~coeff_o;
    end
  end
endmodule
